// >>> rtl/adc_ctrl_defs.svh
/*
  Offsets, field positions, reset values and timing counts of the converter
  control block. Assumes inclusion by bare name from rtl/.
*/
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH

// -----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// -----------------------------------------------------------------------------
`define IDX_PORT_A_PINS 8'h05
`define IDX_INTERRUPT_CONTROL 8'h0b
`define IDX_PERIPH_IRQ_FLAGS 8'h0c
`define IDX_CONV_RESULT 8'h1e
`define IDX_CONV_CONTROL 8'h1f
`define IDX_PORT_A_DIRECTION 8'h85
`define IDX_PERIPH_IRQ_ENABLES 8'h8c
`define IDX_ANALOG_PIN_CONFIG 8'h9f
`define IDX_CC_MODE 8'ha0

// -----------------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------------
`define CTL_CLKSEL_HI 7
`define CTL_CLKSEL_LO 6
`define CTL_CHAN_HI 5
`define CTL_CHAN_LO 3
`define CTL_GO_BIT 2
`define CTL_ON_BIT 0
`define FLAG_CONV_DONE_BIT 6
`define INTCTL_GLOBAL_BIT 7

// -----------------------------------------------------------------------------
// Reset values and codes
// -----------------------------------------------------------------------------
`define RST_CONV_CONTROL 8'h00
`define RST_PIN_CONFIG 3'h0
`define RST_PORT_A_DIR 5'h1f
`define RST_INTERRUPT_CONTROL 8'h00
`define CC_MODE_SPECIAL_TRIGGER 4'hb

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define CLK_PERIOD_NS 8
`define RC_TAD_NS 4000
`define RC_TAD_CYCLES (`RC_TAD_NS / `CLK_PERIOD_NS)
`define HALF_TADS_PER_CONV 19

`endif

// >>> rtl/adc_ctrl_pkg.sv
/*
  Types shared by the converter control block.
  Assumes nothing of its surroundings.
*/
package adc_ctrl_pkg;
  typedef struct packed {
    logic [1:0] clk_sel;
    logic [2:0] channel;
    logic go;
    logic unused;
    logic on;
  } conv_control_t;

  typedef enum logic [1:0] {
    DIV2,
    DIV8,
    DIV32,
    RC_OSC
  } conv_clock_t;
endpackage

// >>> rtl/tad_divider.sv
/*
  Half-period tick generator for the bit conversion clock.
  Assumes the caller restarts it at each conversion start.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defs.svh"

module tad_divider #(
  parameter int RC_HALF = `RC_TAD_CYCLES / 2
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic restart_i,
  input wire adc_ctrl_pkg::conv_clock_t sel_i,
  output logic half_tick_o
);
  logic [11:0] cnt_q;
  logic [11:0] cnt_d;
  wire logic [11:0] half_len;
  wire logic wrap;

  // A half period of 1, 4, 16 oscillator cycles or half the RC period.
  assign half_len = (sel_i == adc_ctrl_pkg::DIV2) ? 12'h001 :
                    (sel_i == adc_ctrl_pkg::DIV8) ? 12'h004 :
                    (sel_i == adc_ctrl_pkg::DIV32) ? 12'h010 : 12'(RC_HALF);
  assign wrap = (cnt_q >= half_len - 12'h001);
  assign cnt_d = (restart_i || wrap) ? 12'h000 : cnt_q + 12'h001;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= 12'h000;
      half_tick_o <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      half_tick_o <= wrap && !restart_i;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/adc_conversion_control.sv
/*
  Converter control: registers, start/abort, timing and result capture of an
  8-bit successive-approximation converter, reached over Avalon-MM.
  Assumes a comparator outside that answers each trial code, and a
  capture/compare unit that pulses the special event trigger.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defs.svh"

module adc_conversion_control #(
  parameter int RC_HALF = `RC_TAD_CYCLES / 2
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [4:0] port_a_in_i,
  input wire logic special_trigger_i,
  input wire logic compare_high_i,
  output logic [4:0] port_a_out_o,
  output logic [4:0] port_a_oe_o,
  output logic [3:0] analog_pin_mask_o,
  output logic vref_from_pin_o,
  output logic [1:0] mux_channel_o,
  output logic hold_disconnect_o,
  output logic [7:0] dac_code_o,
  output logic timer1_clear_o,
  output logic conv_done_irq_o
);
  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  adc_ctrl_pkg::conv_control_t ctl_q;
  logic [2:0] pin_config_select_q;
  logic [4:0] port_latch_q;
  logic [4:0] port_dir_q;
  logic [7:0] intctl_q;
  logic conv_done_irq_flag_q;
  logic conv_done_irq_enable_q;
  logic [3:0] cc_mode_field_q;
  logic [7:0] result_q;
  logic [7:0] sar_q;
  logic [4:0] half_cnt_q;
  logic ack_q;

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  wire logic [7:0] idx = avs_address_i[9:2];
  wire logic wr_lane = avs_write_i && avs_byteenable_i[0] && !ack_q;
  wire logic rd_req = avs_read_i && !ack_q;
  wire logic wr_ctl = wr_lane && (idx == `IDX_CONV_CONTROL);
  wire logic wr_cfg = wr_lane && (idx == `IDX_ANALOG_PIN_CONFIG);
  wire logic wr_res = wr_lane && (idx == `IDX_CONV_RESULT);
  wire logic wr_flg = wr_lane && (idx == `IDX_PERIPH_IRQ_FLAGS);
  wire logic wr_ien = wr_lane && (idx == `IDX_PERIPH_IRQ_ENABLES);
  wire logic wr_int = wr_lane && (idx == `IDX_INTERRUPT_CONTROL);
  wire logic wr_prt = wr_lane && (idx == `IDX_PORT_A_PINS);
  wire logic wr_dir = wr_lane && (idx == `IDX_PORT_A_DIRECTION);
  wire logic wr_ccm = wr_lane && (idx == `IDX_CC_MODE);
  wire logic [7:0] wd = avs_writedata_i[7:0];

  // ---------------------------------------------------------------------------
  // Pin configuration
  // ---------------------------------------------------------------------------
  // Bit 4 of the port is never analog.
  logic [3:0] analog_mask;
  always_comb begin
    case (pin_config_select_q)
      3'h0, 3'h2: analog_mask = 4'hf;
      3'h1, 3'h3: analog_mask = 4'hf;
      3'h4: analog_mask = 4'hb;
      3'h5: analog_mask = 4'hb;
      default: analog_mask = 4'h0;
    endcase
  end
  wire logic vref_pin = (pin_config_select_q[2:1] != 2'h3) && pin_config_select_q[0];
  // Pin 3 used as reference is not an analog input channel for port reads.
  wire logic [3:0] analog_in = analog_mask & ~{vref_pin, 3'h0};
  wire logic [4:0] port_read = {port_a_in_i[4], port_a_in_i[3:0] & ~analog_in};

  // ---------------------------------------------------------------------------
  // Conversion sequencing
  // ---------------------------------------------------------------------------
  wire logic trig_ok = special_trigger_i && ctl_q.on
                       && (cc_mode_field_q == `CC_MODE_SPECIAL_TRIGGER);
  wire logic sw_go = wr_ctl && wd[`CTL_GO_BIT] && wd[`CTL_ON_BIT] && ctl_q.on;
  wire logic busy = ctl_q.go;
  wire logic start = !busy && (sw_go || trig_ok);
  wire logic sw_abort = busy && wr_ctl && (!wd[`CTL_GO_BIT] || !wd[`CTL_ON_BIT]);
  wire logic half_tick;
  wire logic bit_edge = busy && half_tick && half_cnt_q[0] == 1'b0
                        && half_cnt_q < 5'd16;
  wire logic finish = busy && half_tick && (half_cnt_q == 5'(`HALF_TADS_PER_CONV - 1));
  wire logic [2:0] bit_pos = 3'(3'h7 - half_cnt_q[3:1]);

  tad_divider #(
    .RC_HALF(RC_HALF)
  ) u_div (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .restart_i(start),
    .sel_i(adc_ctrl_pkg::conv_clock_t'(ctl_q.clk_sel)),
    .half_tick_o(half_tick)
  );

  // Successive approximation: each trial bit is judged at mid-period.
  logic [7:0] sar_d;
  always_comb begin
    sar_d = sar_q;
    if (start) begin
      sar_d = 8'h80;
    end else if (bit_edge) begin
      sar_d[bit_pos] = compare_high_i;
      if (bit_pos != 3'h0) begin
        sar_d[bit_pos - 3'h1] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctl_q <= `RST_CONV_CONTROL;
      pin_config_select_q <= `RST_PIN_CONFIG;
      port_latch_q <= 5'h00;
      port_dir_q <= `RST_PORT_A_DIR;
      intctl_q <= `RST_INTERRUPT_CONTROL;
      conv_done_irq_flag_q <= 1'b0;
      conv_done_irq_enable_q <= 1'b0;
      cc_mode_field_q <= 4'h0;
      sar_q <= 8'h00;
      half_cnt_q <= 5'h00;
    end else begin
      if (wr_ctl) begin
        ctl_q.clk_sel <= wd[7:6];
        ctl_q.channel <= wd[5:3];
        ctl_q.on <= wd[`CTL_ON_BIT];
      end
      if (start) begin
        ctl_q.go <= 1'b1;
      end else if (finish || sw_abort) begin
        ctl_q.go <= 1'b0;
      end
      if (wr_cfg) pin_config_select_q <= wd[2:0];
      if (wr_prt) port_latch_q <= wd[4:0];
      if (wr_dir) port_dir_q <= wd[4:0];
      if (wr_int) intctl_q <= wd;
      if (wr_ien) conv_done_irq_enable_q <= wd[`FLAG_CONV_DONE_BIT];
      if (wr_ccm) cc_mode_field_q <= wd[3:0];
      // Hardware set wins over a software clear in the same cycle.
      if (finish) begin
        conv_done_irq_flag_q <= 1'b1;
      end else if (wr_flg) begin
        conv_done_irq_flag_q <= wd[`FLAG_CONV_DONE_BIT];
      end
      sar_q <= sar_d;
      half_cnt_q <= start ? 5'h00 : (busy && half_tick) ? half_cnt_q + 5'h01 : half_cnt_q;
    end
  end

  // No reset here: the result survives every reset.
  always_ff @(posedge clk_i) begin
    if (finish) begin
      result_q <= sar_q;
    end else if (wr_res) begin
      result_q <= wd;
    end
  end

  // ---------------------------------------------------------------------------
  // Read mux and bus answer
  // ---------------------------------------------------------------------------
  logic [7:0] rd_byte;
  always_comb begin
    case (idx)
      `IDX_CONV_CONTROL: rd_byte = {ctl_q.clk_sel, ctl_q.channel, ctl_q.go, 1'b0, ctl_q.on};
      `IDX_ANALOG_PIN_CONFIG: rd_byte = {5'h00, pin_config_select_q};
      `IDX_CONV_RESULT: rd_byte = result_q;
      `IDX_PERIPH_IRQ_FLAGS: rd_byte = {1'b0, conv_done_irq_flag_q, 6'h00};
      `IDX_PERIPH_IRQ_ENABLES: rd_byte = {1'b0, conv_done_irq_enable_q, 6'h00};
      `IDX_INTERRUPT_CONTROL: rd_byte = intctl_q;
      `IDX_PORT_A_PINS: rd_byte = {3'h0, port_read};
      `IDX_PORT_A_DIRECTION: rd_byte = {3'h0, port_dir_q};
      `IDX_CC_MODE: rd_byte = {4'h0, cc_mode_field_q};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_q <= 1'b0;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
      port_a_out_o <= 5'h00;
      port_a_oe_o <= 5'h00;
      analog_pin_mask_o <= 4'h0;
      vref_from_pin_o <= 1'b0;
      mux_channel_o <= 2'h0;
      hold_disconnect_o <= 1'b0;
      dac_code_o <= 8'h00;
      timer1_clear_o <= 1'b0;
      conv_done_irq_o <= 1'b0;
    end else begin
      ack_q <= (rd_req || (avs_write_i && !ack_q));
      avs_waitrequest_o <= !(rd_req || (avs_write_i && !ack_q));
      if (rd_req) avs_readdata_o <= {24'h000000, rd_byte};
      // Driven pins keep driving even when analog; the converter then sees that level.
      port_a_out_o <= port_latch_q;
      port_a_oe_o <= ~port_dir_q;
      analog_pin_mask_o <= analog_mask;
      vref_from_pin_o <= vref_pin;
      mux_channel_o <= ctl_q.channel[1:0];
      hold_disconnect_o <= start || (busy && !finish && !sw_abort);
      dac_code_o <= sar_d;
      timer1_clear_o <= special_trigger_i
                        && (cc_mode_field_q == `CC_MODE_SPECIAL_TRIGGER);
      conv_done_irq_o <= intctl_q[`INTCTL_GLOBAL_BIT] && conv_done_irq_enable_q
                         && (conv_done_irq_flag_q || finish);
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  go_after_finish_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    finish |=> !ctl_q.go && conv_done_irq_flag_q && result_q == $past(sar_q))
    else $error("finish did not clear go, set flag and load result");
  trig_off_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (special_trigger_i && !ctl_q.on && !ctl_q.go) |=> !ctl_q.go)
    else $error("trigger started a conversion while converter off");
  trig_start_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (trig_ok && !busy) |=> ctl_q.go && timer1_clear_o)
    else $error("trigger did not start conversion and clear timer");
  cfg_read_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (rd_req && idx == `IDX_ANALOG_PIN_CONFIG) |=> avs_readdata_o[31:3] == 29'h0)
    else $error("pin config upper bits read nonzero");
  abort_keep_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (sw_abort && !finish && !wr_flg && !wr_res) |=> !ctl_q.go
      && conv_done_irq_flag_q == $past(conv_done_irq_flag_q) && $stable(result_q))
    else $error("abort changed result or flag");
  hold_open_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (busy && !finish && !sw_abort) |=> hold_disconnect_o)
    else $error("hold capacitor reconnected during conversion");
  port_analog_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (rd_req && idx == `IDX_PORT_A_PINS) |=> (avs_readdata_o[3:0] & $past(analog_in)) == 4'h0)
    else $error("analog pin read as nonzero");
  fast_len_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (start && ctl_q.clk_sel == 2'h0 && !wr_ctl) ##1 (busy && !wr_ctl) [*8] |->
      (half_cnt_q == 5'd6))
    else $error("divide-by-2 conversion pace wrong");
  // The first half tick trails the divider restart by two cycles, so only six have counted.
  hold_cut_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    start |=> hold_disconnect_o && dac_code_o == 8'h80)
    else $error("start did not cut the hold capacitor with the first trial code");
  abort_release_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    sw_abort |=> !ctl_q.go && !hold_disconnect_o)
    else $error("abort left the conversion running");
  off_go_ignored_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (wr_ctl && !ctl_q.on && !busy) |=> !ctl_q.go)
    else $error("go accepted while converter off");
  digital_pins_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (pin_config_select_q[2:1] == 2'h3) |=> analog_pin_mask_o == 4'h0 && !vref_from_pin_o)
    else $error("all-digital code left a pin analog");
  pin2_digital_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (pin_config_select_q[2:1] == 2'h2) |=> analog_pin_mask_o == 4'hb)
    else $error("pin two not digital for its codes");
  trig_timer_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (special_trigger_i && cc_mode_field_q == `CC_MODE_SPECIAL_TRIGGER) |=> timer1_clear_o)
    else $error("trigger did not clear the timer");
  irq_level_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (intctl_q[`INTCTL_GLOBAL_BIT] && conv_done_irq_enable_q && conv_done_irq_flag_q)
      |=> conv_done_irq_o)
    else $error("done interrupt not raised");
endmodule
`default_nettype wire

// >>> verification/adc_far_side_model.sv
/*
  Far side model: analog sources on four channels and the comparator.
  Assumes hold_i stays high for the whole conversion.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_far_side_model (
  input wire logic clk_i,
  input wire logic [31:0] levels_i,
  input wire logic [1:0] channel_i,
  input wire logic [4:0] pin_out_i,
  input wire logic [4:0] pin_oe_i,
  input wire logic hold_i,
  input wire logic [7:0] code_i,
  output logic compare_high_o
);
  logic [7:0] level;
  logic [7:0] held_q;
  // A pin driven as output presents its own digital level to the converter.
  assign level = pin_oe_i[channel_i] ? {8{pin_out_i[channel_i]}} :
    levels_i[channel_i*8 +: 8];
  // The sample is frozen while the holding capacitor is cut off.
  always_ff @(posedge clk_i) begin
    if (!hold_i) begin
      held_q <= level;
    end
  end
  assign compare_high_o = held_q >= code_i;
endmodule
`default_nettype wire

// >>> verification/adc_conversion_control_bench.sv
/*
  Self-checking bench for the converter control block.
  Assumes the far side model and the design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control_bench;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [9:0] avs_address_i = 10'h000;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [4:0] port_a_in_i = 5'h00;
  logic special_trigger_i = 1'b0;
  logic compare_high_i;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o, vref_from_pin_o, hold_disconnect_o;
  logic timer1_clear_o, conv_done_irq_o;
  logic [4:0] port_a_out_o, port_a_oe_o;
  logic [3:0] analog_pin_mask_o;
  logic [1:0] mux_channel_o;
  logic [7:0] dac_code_o;
  logic [31:0] levels = 32'h3ca55ac3;
  logic [7:0] rd;
  int num_errors = 0;
  int checks = 0;

  always #4 clk_i = ~clk_i;

  adc_conversion_control #(.RC_HALF(4)) DUT (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .port_a_in_i(port_a_in_i), .special_trigger_i(special_trigger_i),
    .compare_high_i(compare_high_i), .port_a_out_o(port_a_out_o), .port_a_oe_o(port_a_oe_o),
    .analog_pin_mask_o(analog_pin_mask_o), .vref_from_pin_o(vref_from_pin_o),
    .mux_channel_o(mux_channel_o), .hold_disconnect_o(hold_disconnect_o),
    .dac_code_o(dac_code_o), .timer1_clear_o(timer1_clear_o),
    .conv_done_irq_o(conv_done_irq_o));

  adc_far_side_model far (.clk_i(clk_i), .levels_i(levels), .channel_i(mux_channel_o),
    .pin_out_i(port_a_out_o), .pin_oe_i(port_a_oe_o), .hold_i(hold_disconnect_o),
    .code_i(dac_code_o), .compare_high_o(compare_high_i));

  task automatic stop_test;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // One Avalon access; the request stands until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= {idx, 2'b00};
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= {24'h0, wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 100);
    rd = avs_readdata_o[7:0];
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (n >= 100) begin
      check("bus_timeout", 8'h00, 8'h01);
      stop_test();
    end
  endtask

  task automatic rdchk(input string name, input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    check(name, exp, rd);
  endtask

  task automatic conv(input logic [1:0] sel, input logic [1:0] ch, input int half,
                      input logic [7:0] exp);
    int n;
    n = 0;
    bus(1'b1, 8'h1f, {sel, 1'b0, ch, 3'b001});
    cyc(4);
    bus(1'b1, 8'h1f, {sel, 1'b0, ch, 3'b101});
    do begin
      @(posedge clk_i);
      n++;
    end while (hold_disconnect_o === 1'b1 && n < 2000);
    check("conv_len", 8'h01, 8'(n >= 19 * half && n <= 19 * half + 3));
    if (n >= 2000) begin
      stop_test();
    end
    rdchk("go_done", 8'h1f, {sel, 1'b0, ch, 3'b001});
    rdchk("result", 8'h1e, exp);
    rdchk("flags", 8'h0c, 8'h40);
    check("irq", 8'h01, {7'h0, conv_done_irq_o});
    bus(1'b1, 8'h0c, 8'h00);
    cyc(2 * 2 * half);
  endtask

  task automatic pulse(input logic exp);
    @(posedge clk_i);
    special_trigger_i <= 1'b1;
    @(posedge clk_i);
    special_trigger_i <= 1'b0;
    @(posedge clk_i);
    check("timer_clear", {7'h0, exp}, {7'h0, timer1_clear_o});
    @(posedge clk_i);
    check("timer_clear_end", 8'h00, {7'h0, timer1_clear_o});
  endtask

  task automatic test_reset;
    logic [7:0] idx[6] = '{8'h1f, 8'h9f, 8'h85, 8'h0c, 8'h8c, 8'h40};
    logic [7:0] exp[6] = '{8'h00, 8'h00, 8'h1f, 8'h00, 8'h00, 8'h00};
    foreach (idx[i]) rdchk("reset_value", idx[i], exp[i]);
    bus(1'b1, 8'h40, 8'hff);
    rdchk("unmapped", 8'h40, 8'h00);
    $display("test reset values done");
  endtask

  task automatic test_pins;
    logic dig;
    logic vr;
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, 8'h9f, {5'h1f, 3'(c)});
      rdchk("pin_cfg_read", 8'h9f, {5'h0, 3'(c)});
      dig = c[2] & c[1];
      vr = c[0] & !dig;
      check("pin_cfg", {3'h0, vr, !dig, !c[2], !dig, !dig},
            {3'h0, vref_from_pin_o, analog_pin_mask_o});
    end
    avs_byteenable_i <= 4'he;
    bus(1'b1, 8'h9f, 8'h05);
    avs_byteenable_i <= 4'hf;
    rdchk("lane_off", 8'h9f, 8'h07);
    port_a_in_i <= 5'h1f;
    bus(1'b1, 8'h9f, 8'h00);
    rdchk("port_analog", 8'h05, 8'h10);
    bus(1'b1, 8'h9f, 8'h04);
    rdchk("port_pin2", 8'h05, 8'h14);
    bus(1'b1, 8'h9f, 8'h06);
    rdchk("port_digital", 8'h05, 8'h1f);
    bus(1'b1, 8'h9f, 8'h00);
    $display("test pin config done");
  endtask

  task automatic test_convert;
    int half[4] = '{1, 4, 16, 4};
    bus(1'b1, 8'h1f, 8'h05);
    rdchk("go_with_on", 8'h1f, 8'h01);
    bus(1'b1, 8'h8c, 8'h40);
    bus(1'b1, 8'h0b, 8'h80);
    for (int s = 0; s < 4; s++) conv(2'(s), 2'(s), half[s], levels[s*8 +: 8]);
    check("irq_cleared", 8'h00, {7'h0, conv_done_irq_o});
    bus(1'b1, 8'h05, 8'h01);
    bus(1'b1, 8'h85, 8'h1e);
    conv(2'h0, 2'h0, 1, 8'hff);
    check("port_drive", 8'h01, {3'h0, port_a_oe_o & port_a_out_o});
    $display("test conversions done");
  endtask

  task automatic test_abort;
    bus(1'b1, 8'h1f, 8'h89);
    bus(1'b1, 8'h1f, 8'h8d);
    cyc(20);
    check("busy", 8'h01, {7'h0, hold_disconnect_o});
    bus(1'b1, 8'h1f, 8'h89);
    cyc(400);
    check("aborted", 8'h00, {7'h0, hold_disconnect_o});
    rdchk("abort_result", 8'h1e, 8'hff);
    rdchk("abort_flag", 8'h0c, 8'h00);
    $display("test abort done");
  endtask

  task automatic test_trigger;
    bus(1'b1, 8'h1f, 8'h00);
    bus(1'b1, 8'ha0, 8'h0b);
    pulse(1'b1);
    rdchk("off_ignored", 8'h1f, 8'h00);
    bus(1'b1, 8'h1f, 8'h01);
    cyc(4);
    pulse(1'b1);
    rdchk("trig_go", 8'h1f, 8'h05);
    cyc(30);
    rdchk("trig_done", 8'h1f, 8'h01);
    rdchk("trig_result", 8'h1e, 8'hff);
    bus(1'b1, 8'ha0, 8'h0a);
    pulse(1'b0);
    $display("test trigger done");
  endtask

  task automatic test_reset_mid;
    bus(1'b1, 8'h1f, 8'h89);
    bus(1'b1, 8'h1f, 8'h8d);
    cyc(50);
    reset_n_i <= 1'b0;
    cyc(2);
    reset_n_i <= 1'b1;
    check("reset_abort", 8'h00, {7'h0, hold_disconnect_o});
    rdchk("result_kept", 8'h1e, 8'hff);
    rdchk("control_off", 8'h1f, 8'h00);
    $display("test reset mid conversion done");
  endtask

  initial begin
    cyc(20);
    reset_n_i <= 1'b1;
    test_reset();
    test_pins();
    test_convert();
    test_abort();
    test_trigger();
    test_reset_mid();
    stop_test();
  end
endmodule
`default_nettype wire
